//--- shared/ssd_defines.svh
/*
 * Named constants of the split-segment instruction decompressor: register
 * offsets, register widths and status bit positions, reset values and bypass codes.
 * Assumes it is included by bare name from the design files that need it.
 */
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte offsets, one aligned word each)
// ----------------------------------------------------------------
`define SSD_ADDR_W 8
`define SSD_REG_CFG 8'h00
`define SSD_REG_BASE1 8'h04
`define SSD_REG_BASE2 8'h08
`define SSD_REG_STATUS 8'h0c

// ----------------------------------------------------------------
// configuration, base and status register fields
// ----------------------------------------------------------------
`define SSD_CFG_W 10
`define SSD_CFG_RESET 10'h0e9
`define SSD_BASE_W 16
`define SSD_BASE_RESET 16'h0000
`define SSD_STAT_CNT_W 16
`define SSD_STAT_ERRCLS_BIT 16
`define SSD_STAT_ERRCFG_BIT 17
`define SSD_STAT_BUSY_BIT 18

// ----------------------------------------------------------------
// instruction layout and codes
// ----------------------------------------------------------------
`define SSD_CLASS_W 4
`define SSD_BODY_W 28
`define SSD_SEG_W 16
`define SSD_IDX_W 9
`define SSD_IDX_MIN 4'h2
`define SSD_IDX_MAX 4'h9
`define SSD_BYP_ZERO 4'hb
`define SSD_BYP_TEN 4'hc
`define SSD_BYP_FIFTEEN 4'hd
`define SSD_BYP_FULL 4'he
`define SSD_CLASS_CODE_DEF 4'h3

`endif

//--- shared/ssd_pkg.sv
/*
 * Types shared by the decompressor modules: configuration, parsed fields,
 * bus request, state encodings and the state records of the RAM request stage and the core.
 * Assumes ssd_defines.svh is on the include path.
 */
`default_nettype none
`include "ssd_defines.svh"

package ssd_pkg;

   // ----------------------------------------------------------------
   // configuration, parsed fields, bus request and state encoding
   // ----------------------------------------------------------------
   typedef struct packed {
      logic swap;              // segment_swap_select
      logic rsel;              // vocab_ram_select
      logic [3:0] byp_code;    // lower_bypass_setting
      logic [3:0] idx_len;     // upper_index_setting
   } ssd_cfg_type;

   typedef struct packed {
      logic legal;
      logic class_ok;
      logic bad_cfg;
      logic [`SSD_IDX_W-1:0] index;
      logic [`SSD_SEG_W-1:0] lower;
   } ssd_fields_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [`SSD_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } ssd_bus_req_type;

   typedef enum logic [1:0] {
      SSD_IDLE = 2'b00,
      SSD_LOOK = 2'b01,
      SSD_WAIT = 2'b10
   } ssd_state_type;

   // ----------------------------------------------------------------
   // module state records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rd1;
      logic rd2;
      logic sel;
      logic [`SSD_BASE_W-1:0] addr1;
      logic [`SSD_BASE_W-1:0] addr2;
   } ssd_vport_type;

   typedef struct packed {
      ssd_state_type state;
      logic in_ready;
      logic out_valid;
      logic [31:0] out_word;
      logic err;
      logic err_class;
      logic err_cfg;
      ssd_cfg_type cfg;
      logic [`SSD_BASE_W-1:0] base1;
      logic [`SSD_BASE_W-1:0] base2;
      logic [31:0] rdata;
      logic [`SSD_STAT_CNT_W-1:0] done_cnt;
      logic [`SSD_SEG_W-1:0] lower;
   } ssd_core_type;

endpackage

`default_nettype wire

//--- hw/ssd_field_parse.sv
/*
 * Combinational parser of one compressed word: splits class code, upper
 * index and lower bypass field, and expands the lower field to 16 bits.
 * Assumes the compressed bits are left aligned in the 32-bit word.
 */
`default_nettype none
`include "ssd_defines.svh"

module ssd_field_parse
   import ssd_pkg::*;
#(
   parameter logic [3:0] CLASS_CODE = `SSD_CLASS_CODE_DEF
) (
   input wire logic [31:0] word,        // compressed word, class code in the top nibble
   input wire ssd_cfg_type cfg,         // current configuration
   output var ssd_fields_type fields    // parsed and expanded fields
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // bypass length code to field width in bits
   function automatic logic [4:0] byp_width(input logic [3:0] code);
      case (code)
         `SSD_BYP_TEN: return 5'd10;
         `SSD_BYP_FIFTEEN: return 5'd15;
         `SSD_BYP_FULL: return 5'd16;
         default: return 5'd0;
      endcase
   endfunction

   // fixed expansion of short bypass fields; not programmable on purpose
   function automatic logic [15:0] expand_lower(input logic [3:0] code, input logic [15:0] raw);
      case (code)
         `SSD_BYP_TEN: return {{6{raw[9]}}, raw[9:0]};
         `SSD_BYP_FIFTEEN: return {1'b0, raw[14:0]};
         `SSD_BYP_FULL: return raw;
         default: return 16'h0000;
      endcase
   endfunction

   logic [`SSD_BODY_W-1:0] body;
   logic [`SSD_BODY_W-1:0] after_idx;
   logic [15:0] byp_top;
   logic [15:0] byp_raw;
   logic len_ok;
   logic code_ok;

   // ----------------------------------------------------------------
   // field split: class, then index, then bypass
   // ----------------------------------------------------------------
   always_comb begin
      body = word[`SSD_BODY_W-1:0];
      after_idx = body << cfg.idx_len;
      byp_top = after_idx[`SSD_BODY_W-1 -: `SSD_SEG_W];
      byp_raw = byp_top >> (5'd16 - byp_width(cfg.byp_code));
      len_ok = (cfg.idx_len >= `SSD_IDX_MIN) && (cfg.idx_len <= `SSD_IDX_MAX);
      code_ok = (cfg.byp_code >= `SSD_BYP_ZERO) && (cfg.byp_code <= `SSD_BYP_FULL);
      fields.index = body[`SSD_BODY_W-1 -: `SSD_IDX_W] >> (`SSD_IDX_MAX - cfg.idx_len);
      fields.lower = expand_lower(cfg.byp_code, byp_raw);
      fields.class_ok = (word[31 -: `SSD_CLASS_W] == CLASS_CODE);
      // a swapped layout has no path here, so it is refused
      fields.bad_cfg = !len_ok || !code_ok || cfg.swap;
      fields.legal = fields.class_ok && !fields.bad_cfg;
   end

endmodule

`default_nettype wire

//--- hw/ssd_vocab_port.sv
/*
 * Request stage toward the two vocabulary RAMs: forms base plus index,
 * raises the read of the selected RAM for one cycle and returns its word.
 * Assumes each RAM answers with read data in the cycle after its read.
 */
`default_nettype none
`include "ssd_defines.svh"

module ssd_vocab_port
   import ssd_pkg::*;
#(
   parameter int AW = 10
) (
   input wire logic clk,                         // core clock
   input wire logic nrst,                        // async reset, active low
   input wire logic issue,                       // one-cycle lookup request
   input wire logic rsel,                        // 0 first RAM, 1 second RAM
   input wire logic [`SSD_BASE_W-1:0] base1,     // vocabulary base in first RAM
   input wire logic [`SSD_BASE_W-1:0] base2,     // vocabulary base in second RAM
   input wire logic [`SSD_IDX_W-1:0] index,      // upper-segment index
   input wire logic [15:0] ram1_rdata,           // first RAM read data
   input wire logic [15:0] ram2_rdata,           // second RAM read data
   output logic ram1_rd,                         // first RAM read strobe
   output logic [AW-1:0] ram1_addr,              // first RAM address
   output logic ram2_rd,                         // second RAM read strobe
   output logic [AW-1:0] ram2_addr,              // second RAM address
   output logic [15:0] vocab_data                // word of the selected RAM
);

   ssd_vport_type v_r;
   ssd_vport_type v_nxt;

   // the index points into the table at the programmed base
   function automatic logic [`SSD_BASE_W-1:0] entry_addr(input logic [`SSD_BASE_W-1:0] base,
                                                          input logic [`SSD_IDX_W-1:0] idx);
      return base + `SSD_BASE_W'(idx);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      v_nxt = v_r;
      v_nxt.rd1 = 1'b0;
      v_nxt.rd2 = 1'b0;
      if (issue) begin
         v_nxt.sel = rsel;
         v_nxt.rd1 = !rsel;
         v_nxt.rd2 = rsel;
         v_nxt.addr1 = entry_addr(base1, index);
         v_nxt.addr2 = entry_addr(base2, index);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         v_r <= '0;
      end else begin
         v_r <= v_nxt;
      end
   end

   assign ram1_rd = v_r.rd1;
   assign ram2_rd = v_r.rd2;
   assign ram1_addr = v_r.addr1[AW-1:0];
   assign ram2_addr = v_r.addr2[AW-1:0];
   // the selection is held, so the answer is taken from the RAM that was read
   assign vocab_data = v_r.sel ? ram2_rdata : ram1_rdata;

endmodule

`default_nettype wire

//--- hw/ssd_decomp.sv
/*
 * Top of the split-segment instruction decompressor: register port,
 * acceptance of compressed words, vocabulary lookup sequencing and the
 * rebuilt 32-bit instruction.
 * Assumes fetch holds in_valid and in_word until in_ready takes them, and
 * that the vocabulary RAMs answer one cycle after a read strobe.
 */
// The register offsets and strobed register access were decided locally.
`default_nettype none
`include "ssd_defines.svh"

// Functional notes
// - rebuilt word: upper from vocabulary, lower bypass
// - upper and lower segments use separate methods
// - index points into vocabulary, entry fetched
// - parse class, then index, then bypass field
// - lower from full or shorter bypass field
// - short bypass expanded by fixed rules
// - codes b,c,d,e mean 0,10,15,16 bits
// - vocabulary base address is programmable
// - first RAM uses first base setting
// - second RAM uses second base setting
// - select 0 first RAM, 1 second RAM
module ssd_decomp
   import ssd_pkg::*;
#(
   parameter int AW = 10,                           // vocabulary RAM address width
   parameter logic [3:0] CLASS_CODE = `SSD_CLASS_CODE_DEF // class code, arbitrary value
) (
   input wire logic clk,                            // core clock, 100 MHz
   input wire logic nrst,                           // async reset, active low
   input wire ssd_bus_req_type bus,                 // register write/read request
   output logic [31:0] bus_rdata,                   // read data, cycle after read
   input wire logic in_valid,                       // compressed word offered
   input wire logic [31:0] in_word,                 // compressed word, left aligned
   output logic in_ready,                           // block can take a word
   output logic out_valid,                          // rebuilt word, one-cycle pulse
   output logic [31:0] out_word,                    // rebuilt instruction
   output logic err,                                // word refused, one-cycle pulse
   output logic ram1_rd,                            // first vocabulary RAM read
   output logic [AW-1:0] ram1_addr,                 // first vocabulary RAM address
   input wire logic [15:0] ram1_rdata,              // first vocabulary RAM data
   output logic ram2_rd,                            // second vocabulary RAM read
   output logic [AW-1:0] ram2_addr,                 // second vocabulary RAM address
   input wire logic [15:0] ram2_rdata               // second vocabulary RAM data
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the index reaches 9 bits and bases are held in 16 bits
   if (AW < `SSD_IDX_W || AW > `SSD_BASE_W) begin : g_bad_aw
      $error("ssd_decomp: AW must lie between 9 and 16");
   end

   ssd_core_type c_r;
   ssd_core_type c_nxt;
   ssd_fields_type fields;
   logic [15:0] vocab_data;
   logic take_w;
   logic issue_w;

   // ----------------------------------------------------------------
   // field parser and RAM request stage
   // ----------------------------------------------------------------
   ssd_field_parse #(
      .CLASS_CODE(CLASS_CODE)
   ) u_parse (
      .word(in_word),
      .cfg(c_r.cfg),
      .fields(fields)
   );

   ssd_vocab_port #(
      .AW(AW)
   ) u_vport (
      .clk(clk),
      .nrst(nrst),
      .issue(issue_w),
      .rsel(c_r.cfg.rsel),
      .base1(c_r.base1),
      .base2(c_r.base2),
      .index(fields.index),
      .ram1_rdata(ram1_rdata),
      .ram2_rdata(ram2_rdata),
      .ram1_rd(ram1_rd),
      .ram1_addr(ram1_addr),
      .ram2_rd(ram2_rd),
      .ram2_addr(ram2_addr),
      .vocab_data(vocab_data)
   );

   // a word is taken only while idle; in_ready mirrors that state
   assign take_w = (c_r.state == SSD_IDLE) && in_valid;
   assign issue_w = take_w && fields.legal;

   // ----------------------------------------------------------------
   // next state: registers, then the lookup sequence
   // ----------------------------------------------------------------
   always_comb begin
      c_nxt = c_r;
      c_nxt.out_valid = 1'b0;
      c_nxt.err = 1'b0;
      c_nxt.rdata = 32'h0000_0000;
      // register writes; status is read only
      if (bus.wr) begin
         case (bus.addr)
            `SSD_REG_CFG: c_nxt.cfg = ssd_cfg_type'(bus.wdata[`SSD_CFG_W-1:0]);
            `SSD_REG_BASE1: c_nxt.base1 = bus.wdata[`SSD_BASE_W-1:0];
            `SSD_REG_BASE2: c_nxt.base2 = bus.wdata[`SSD_BASE_W-1:0];
            default: ;
         endcase
      end
      // register reads; unmapped offsets answer zero
      if (bus.rd) begin
         case (bus.addr)
            `SSD_REG_CFG: c_nxt.rdata = {22'h0, c_r.cfg};
            `SSD_REG_BASE1: c_nxt.rdata = {16'h0000, c_r.base1};
            `SSD_REG_BASE2: c_nxt.rdata = {16'h0000, c_r.base2};
            `SSD_REG_STATUS: begin
               c_nxt.rdata[`SSD_STAT_CNT_W-1:0] = c_r.done_cnt;
               c_nxt.rdata[`SSD_STAT_ERRCLS_BIT] = c_r.err_class;
               c_nxt.rdata[`SSD_STAT_ERRCFG_BIT] = c_r.err_cfg;
               c_nxt.rdata[`SSD_STAT_BUSY_BIT] = (c_r.state != SSD_IDLE);
            end
            default: c_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // lookup sequence: take, read RAM, capture its answer
      case (c_r.state)
         SSD_IDLE: begin
            if (take_w) begin
               c_nxt.err_class = !fields.class_ok;
               c_nxt.err_cfg = fields.bad_cfg;
               if (fields.legal) begin
                  c_nxt.lower = fields.lower;
                  c_nxt.state = SSD_LOOK;
                  c_nxt.in_ready = 1'b0;
               end else begin
                  // refused words produce no lookup and no output word
                  c_nxt.err = 1'b1;
               end
            end
         end
         SSD_LOOK: begin
            c_nxt.state = SSD_WAIT;
         end
         SSD_WAIT: begin
            c_nxt.out_valid = 1'b1;
            c_nxt.out_word = {vocab_data, c_r.lower};
            c_nxt.done_cnt = c_r.done_cnt + 16'h0001;
            c_nxt.state = SSD_IDLE;
            c_nxt.in_ready = 1'b1;
         end
         default: begin
            c_nxt.state = SSD_IDLE;
            c_nxt.in_ready = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         c_r <= '0;
         c_r.state <= SSD_IDLE;
         c_r.in_ready <= 1'b1;
         c_r.cfg <= ssd_cfg_type'(`SSD_CFG_RESET);
         c_r.base1 <= `SSD_BASE_RESET;
         c_r.base2 <= `SSD_BASE_RESET;
      end else begin
         c_r <= c_nxt;
      end
   end

   // outputs straight from the state record
   assign bus_rdata = c_r.rdata;
   assign in_ready = c_r.in_ready;
   assign out_valid = c_r.out_valid;
   assign out_word = c_r.out_word;
   assign err = c_r.err;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic [AW-1:0] exp_addr1;
   logic [AW-1:0] exp_addr2;
   assign exp_addr1 = c_r.base1[AW-1:0] + AW'(fields.index);
   assign exp_addr2 = c_r.base2[AW-1:0] + AW'(fields.index);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   lookup_issued_a: assert property (
      issue_w |=> (ram1_rd ^ ram2_rd))
      else $error("legal word did not read exactly one vocabulary RAM");

   first_ram_addr_a: assert property (
      issue_w && !c_r.cfg.rsel |=> ram1_rd && !ram2_rd && ram1_addr == $past(exp_addr1))
      else $error("first RAM lookup wrong strobe or address");

   second_ram_addr_a: assert property (
      issue_w && c_r.cfg.rsel |=> ram2_rd && !ram1_rd && ram2_addr == $past(exp_addr2))
      else $error("second RAM lookup wrong strobe or address");

   result_timing_a: assert property (
      issue_w |-> ##1 (!in_ready && !out_valid) [*2] ##1 (out_valid && in_ready))
      else $error("rebuilt word not delivered three cycles after take");

   upper_vocab_a: assert property (
      c_r.state == SSD_WAIT |=> out_word[31:16] == $past(vocab_data))
      else $error("upper half not taken from vocabulary data");

   lower_bypass_a: assert property (
      issue_w |-> ##3 out_word[15:0] == $past(fields.lower, 3))
      else $error("lower half does not match bypass field");

   zero_bypass_a: assert property (
      issue_w && c_r.cfg.byp_code == `SSD_BYP_ZERO |-> ##3 out_word[15:0] == 16'h0000)
      else $error("zero-length bypass did not give a zero lower half");

   refuse_bad_a: assert property (
      take_w && !fields.legal |=> err && !ram1_rd && !ram2_rd && in_ready)
      else $error("refused word started a lookup or gave no error pulse");

   swap_refused_a: assert property (
      take_w && c_r.cfg.swap |=> err && !out_valid)
      else $error("segment swap set but word was not refused");

   // register port: read answers one cycle late, writes land in the next cycle too
   read_base_a: assert property (
      bus.rd && bus.addr == `SSD_REG_BASE1 |=> bus_rdata == {16'h0000, $past(c_r.base1)})
      else $error("base read did not answer in the next cycle");

   read_idle_a: assert property (
      !bus.rd |=> bus_rdata == 32'h0000_0000)
      else $error("read data stood longer than one cycle");

   cfg_write_a: assert property (
      bus.wr && bus.addr == `SSD_REG_CFG |=> c_r.cfg == $past(bus.wdata[`SSD_CFG_W-1:0]))
      else $error("configuration write did not land");

   base1_write_a: assert property (
      bus.wr && bus.addr == `SSD_REG_BASE1 |=> c_r.base1 == $past(bus.wdata[`SSD_BASE_W-1:0]))
      else $error("first base write did not land");

   base2_write_a: assert property (
      bus.wr && bus.addr == `SSD_REG_BASE2 |=> c_r.base2 == $past(bus.wdata[`SSD_BASE_W-1:0]))
      else $error("second base write did not land");

   // ----------------------------------------------------------------
   // lower-segment and refusal checks built from the raw word, not from the parser
   // ----------------------------------------------------------------
   // bypass bits right below the index, left aligned, as fetch offered them
   logic [`SSD_BODY_W-1:0] shifted_body;
   logic [`SSD_SEG_W-1:0] lead_field;
   assign shifted_body = in_word[`SSD_BODY_W-1:0] << c_r.cfg.idx_len;
   assign lead_field = shifted_body[`SSD_BODY_W-1 -: `SSD_SEG_W];

   full_bypass_a: assert property (
      issue_w && c_r.cfg.byp_code == `SSD_BYP_FULL |-> ##3 out_word[15:0] == $past(lead_field, 3))
      else $error("full bypass field not copied as is");

   ten_bypass_a: assert property (
      issue_w && c_r.cfg.byp_code == `SSD_BYP_TEN |-> ##3 out_word[15:0] == 16'($signed($past(lead_field, 3)) >>> 6))
      else $error("ten-bit bypass not sign extended");

   fifteen_bypass_a: assert property (
      issue_w && c_r.cfg.byp_code == `SSD_BYP_FIFTEEN |-> ##3 out_word[15:0] == ($past(lead_field, 3) >> 1))
      else $error("fifteen-bit bypass not zero extended");

   class_bad_a: assert property (
      take_w && in_word[31 -: `SSD_CLASS_W] != CLASS_CODE |=> err && !out_valid)
      else $error("word of another class was not refused");

   len_range_a: assert property (
      take_w && (c_r.cfg.idx_len < `SSD_IDX_MIN || c_r.cfg.idx_len > `SSD_IDX_MAX) |=> err && !ram1_rd && !ram2_rd)
      else $error("index length out of range was not refused");

   code_range_a: assert property (
      take_w && (c_r.cfg.byp_code < `SSD_BYP_ZERO || c_r.cfg.byp_code > `SSD_BYP_FULL) |=> err && !ram1_rd)
      else $error("unknown bypass code was not refused");

   // one lookup never reads twice, and the block is free when it answers
   strobe_single_a: assert property (
      ram1_rd || ram2_rd |=> !ram1_rd && !ram2_rd)
      else $error("vocabulary read strobe longer than one cycle");

   ready_back_a: assert property (
      out_valid |-> in_ready)
      else $error("block not ready in the cycle of its answer");

   count_step_a: assert property (
      out_valid |-> c_r.done_cnt == $past(c_r.done_cnt) + 16'h0001)
      else $error("done count did not step with the answer");

endmodule

`default_nettype wire

//--- bench/ssd_vocab_model.sv
/*
 * Behavioural model of the two vocabulary RAMs behind the decompressor.
 * Assumes read data are taken only in the cycle after a read strobe.
 */
`default_nettype none

module ssd_vocab_model #(
   parameter int AW = 10
) (
   input wire logic clk,                 // core clock
   input wire logic nrst,                // async reset, active low
   input wire logic ram1_rd,             // first RAM read strobe
   input wire logic [AW-1:0] ram1_addr,  // first RAM address
   output logic [15:0] ram1_rdata,       // first RAM data
   input wire logic ram2_rd,             // second RAM read strobe
   input wire logic [AW-1:0] ram2_addr,  // second RAM address
   output logic [15:0] ram2_rdata        // second RAM data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // read ports
   // ----------------------------------------------------------------
   // contents are address xor a per-RAM tag; outside the answer cycle the
   // lines toggle so a late sample never meets a stale word
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ram1_rdata <= 16'h0000;
         ram2_rdata <= 16'h0000;
      end else begin
         ram1_rdata <= ram1_rd ? (16'h5000 ^ 16'(ram1_addr)) : ~ram1_rdata;
         ram2_rdata <= ram2_rd ? (16'ha000 ^ 16'(ram2_addr)) : ~ram2_rdata;
      end
   end
endmodule

`default_nettype wire

//--- bench/testbench.sv
/*
 * Self-checking bench of the decompressor: register calls, legal words over
 * every bypass code and both RAMs, and refused words.
 * Assumes the vocabulary model answers one cycle after each strobe.
 */
`default_nettype none
`include "ssd_defines.svh"

module testbench
   import ssd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0] CLS = 4'h3;
   localparam logic [15:0] BASE1 = 16'h0123;
   localparam logic [15:0] BASE2 = 16'h03f0;
   logic clk = 1'b0;
   logic nrst;
   ssd_bus_req_type bus;
   logic [31:0] bus_rdata, in_word, out_word, exp;
   logic in_valid, in_ready, out_valid, err, ram1_rd, ram2_rd;
   logic [9:0] ram1_addr, ram2_addr, ea;
   logic [15:0] ram1_rdata, ram2_rdata;
   int err_total, total_checks;
   logic [3:0] lens [4] = '{4'h2, 4'h9, 4'h5, 4'h7};
   logic [27:0] bodies [4] = '{28'h9a53c7b, 28'hfffa5c3, 28'h36e81d4, 28'hc1b7f29};
   logic [15:0] bads [6] = '{16'h50e9, 16'h30e1, 16'h30ea, 16'h30a9, 16'h30f9, 16'h32e9};

   always #5 clk = ~clk;

   ssd_decomp #(.AW(10), .CLASS_CODE(CLS)) u_dut (.clk(clk), .nrst(nrst), .bus(bus), .bus_rdata(bus_rdata),
      .in_valid(in_valid), .in_word(in_word), .in_ready(in_ready), .out_valid(out_valid), .out_word(out_word),
      .err(err), .ram1_rd(ram1_rd), .ram1_addr(ram1_addr), .ram1_rdata(ram1_rdata), .ram2_rd(ram2_rd),
      .ram2_addr(ram2_addr), .ram2_rdata(ram2_rdata));
   ssd_vocab_model #(.AW(10)) u_ram (.clk(clk), .nrst(nrst), .ram1_rd(ram1_rd), .ram1_addr(ram1_addr),
      .ram1_rdata(ram1_rdata), .ram2_rd(ram2_rd), .ram2_addr(ram2_addr), .ram2_rdata(ram2_rdata));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      total_checks++;
      if (got !== want) begin
         err_total++;
         $display("mismatch at %0t got %h want %h", $time, got, want);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask

   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus <= '0;
      #1;
      chk(bus_rdata, want);
   endtask

   // expected word from the layout: index below the class, then bypass
   function automatic logic [31:0] build(input logic [3:0] il, input logic [3:0] bc, input logic rs,
                                         input logic [27:0] b, output logic [9:0] a);
      logic [27:0] idx;
      logic [27:0] fld;
      logic [15:0] lo;
      idx = b >> (28 - il);
      fld = b << il;
      a = 10'((rs ? BASE2[9:0] : BASE1[9:0]) + idx[9:0]);
      case (bc)
         4'hb: lo = 16'h0000;
         4'hc: lo = {{6{fld[27]}}, fld[27:18]};
         4'hd: lo = {1'b0, fld[27:13]};
         default: lo = fld[27:12];
      endcase
      return {(rs ? 16'ha000 : 16'h5000) ^ {6'h00, a}, lo};
   endfunction

   // offer one word; bad words must be refused in c1, good ones answer in c3
   task automatic send(input logic [31:0] w, input logic [31:0] want, input logic bad, input logic rs);
      int n;
      @(posedge clk);
      in_valid <= 1'b1;
      in_word <= w;
      @(posedge clk);
      in_valid <= 1'b0;
      for (n = 1; n <= 8; n++) begin
         #1;
         if (n == 1) begin
            chk(32'({ram1_rd, ram2_rd}), bad ? 32'h0 : (rs ? 32'h1 : 32'h2));
            if (!bad) chk(32'(rs ? ram2_addr : ram1_addr), 32'(ea));
         end
         if (out_valid === 1'b1 || err === 1'b1) break;
         @(posedge clk);
      end
      if (n > 8) begin
         err_total++;
         complete_run();
      end
      chk(32'(n), bad ? 32'h1 : 32'h3);
      chk(32'({out_valid, err}), bad ? 32'h1 : 32'h2);
      if (!bad) chk(out_word, want);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      bus = '0;
      in_valid = 1'b0;
      in_word = 32'h0;
      nrst = 1'b0;
      err_total = 0;
      total_checks = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk(32'(in_ready), 32'h1);
      rd_chk(`SSD_REG_CFG, 32'h000000e9);
      rd_chk(`SSD_REG_BASE1, 32'h0);
      rd_chk(8'h10, 32'h0);
      wr(`SSD_REG_BASE1, 32'(BASE1));
      wr(`SSD_REG_BASE2, 32'(BASE2));
      rd_chk(`SSD_REG_BASE2, 32'(BASE2));
      // every bypass code, both RAMs; base two wraps past the top of its RAM
      for (int i = 0; i < 4; i++) begin
         wr(`SSD_REG_CFG, {22'h0, 1'b0, 1'(i), 4'(4'hb + i), lens[i]});
         exp = build(lens[i], 4'(4'hb + i), 1'(i), bodies[i], ea);
         send({CLS, bodies[i]}, exp, 1'b0, 1'(i));
      end
      rd_chk(`SSD_REG_STATUS, 32'h00000004);
      // refused: bad class, index lengths 1 and 10, codes a and f, swap set
      for (int j = 0; j < 6; j++) begin
         wr(`SSD_REG_CFG, {22'h0, bads[j][9:0]});
         send({bads[j][15:12], bodies[0]}, 32'h0, 1'b1, 1'b0);
         rd_chk(`SSD_REG_STATUS, (j == 0) ? 32'h00010004 : 32'h00020004);
      end
      complete_run();
   end
endmodule

`default_nettype wire
